// ### hmap_pkg.sv
/*
  Shared constants for the host memory access port: widths, timing figures and cycle counts.
  Assumes a single 50 MHz clock shared by both ends of the port.
*/
package hmap_pkg;
  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_PS = 20000;
  // Processor cycle expressed in picoseconds; least busy time is 1.5 of them
  localparam int PROC_CYCLE_PS = 20000;
  localparam int MIN_BUSY_PS = (PROC_CYCLE_PS * 3) / 2;
  // Least time rounds up to whole clock cycles
  localparam int MIN_BUSY_CYC = (MIN_BUSY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BUSY_CNT_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 16'h0001;
  // Pin levels of an idle port: select high, latch low, write and read strobes high
  localparam logic [3:0] CTL_IDLE = 4'hB;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [BUSY_CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [BUSY_CNT_W-1:0] CNT_ONE = 8'h01;
endpackage : hmap_pkg

// ### hmap_if.sv
/*
  Pin-level carrier between the host end and the device end of the port.
  Resolves the shared bus itself from the two output enables, the host end taking priority.
*/
interface hmap_if;
  logic port_select_n;
  logic address_latch_strobe;
  logic write_strobe_n;
  logic read_strobe_n;
  logic port_acknowledge_n;
  logic [15:0] bus_from_host;
  logic bus_from_host_oe;
  logic [15:0] bus_from_device;
  logic bus_from_device_oe;
  logic [15:0] shared_addr_data_bus;

  // Wire level of the shared bus worked out from the enables
  always_comb
  begin
    if (bus_from_host_oe)
      shared_addr_data_bus = bus_from_host;
    else if (bus_from_device_oe)
      shared_addr_data_bus = bus_from_device;
    else
      shared_addr_data_bus = 16'hFFFF;
  end

  modport device (
    input port_select_n, address_latch_strobe, write_strobe_n, read_strobe_n,
    input shared_addr_data_bus,
    output port_acknowledge_n, bus_from_device, bus_from_device_oe
  );
  modport host (
    output port_select_n, address_latch_strobe, write_strobe_n, read_strobe_n,
    output bus_from_host, bus_from_host_oe,
    input port_acknowledge_n, shared_addr_data_bus
  );
endinterface : hmap_if

// ### hmap_device.sv
/*
  Device end of the host memory access port: latches addresses, takes write data and
  paces each write with the acknowledge, handing words to on-chip memory.
  Assumes pins are asynchronous to i_clk and are synchronised here; memory accepts a
  write in the cycle it is offered.
*/
module hmap_device #(
  parameter int MIN_BUSY = hmap_pkg::MIN_BUSY_CYC // Least busy cycles after write start
) (
  input wire logic i_clk, // System clock
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic i_clk_en, // Clock enable, freezes state when low
  hmap_if.device port, // Pin side
  output logic o_mem_we, // Memory write pulse
  output logic [hmap_pkg::ADDR_W-1:0] o_mem_addr, // Memory write address
  output logic [hmap_pkg::DATA_W-1:0] o_mem_data // Memory write data
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] ctl_s1_q;
  logic [3:0] ctl_s2_q;
  logic [hmap_pkg::DATA_W-1:0] bus_s1_q;
  logic [hmap_pkg::DATA_W-1:0] bus_s2_q;
  logic [hmap_pkg::DATA_W-1:0] bus_s3_q;
  logic sel_n, alat, wr_n;
  logic alat_act_q, wr_act_q;
  logic alat_act, wr_act;

  // Two flops before any logic; bus gets a third stage so data lines up with strobe
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ctl_s1_q <= hmap_pkg::CTL_IDLE; // Idle levels, so no false phase edge follows reset
      ctl_s2_q <= hmap_pkg::CTL_IDLE;
      bus_s1_q <= hmap_pkg::DATA_RESET;
      bus_s2_q <= hmap_pkg::DATA_RESET;
      bus_s3_q <= hmap_pkg::DATA_RESET;
    end
    else if (i_clk_en)
    begin
      ctl_s1_q <= {port.port_select_n, port.address_latch_strobe, port.write_strobe_n,
                   port.read_strobe_n};
      ctl_s2_q <= ctl_s1_q;
      bus_s1_q <= port.shared_addr_data_bus;
      bus_s2_q <= bus_s1_q;
      bus_s3_q <= bus_s2_q;
    end
  end

  assign sel_n = ctl_s2_q[3];
  assign alat = ctl_s2_q[2];
  assign wr_n = ctl_s2_q[1];
  assign alat_act = !sel_n && alat;
  assign wr_act = !sel_n && !wr_n;

  // Previous phase levels for end detection
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      alat_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      alat_act_q <= alat_act;
      wr_act_q <= wr_act;
    end
  end

  // ---------------------------------------------------------------
  // Write pacing
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_WAIT_END = 2'b11,
    ST_COMMIT = 2'b10
  } state_t;

  state_t state_q;
  logic [hmap_pkg::BUSY_CNT_W-1:0] busy_cnt_q;
  logic data_taken_q;
  logic [hmap_pkg::DATA_W-1:0] wdata_q;
  logic [hmap_pkg::ADDR_W-1:0] addr_q;
  logic wr_start, wr_end, busy_done;

  assign wr_start = wr_act && !wr_act_q;
  assign wr_end = !wr_act && wr_act_q;
  assign busy_done = (busy_cnt_q <= hmap_pkg::CNT_ONE);

  // Busy is held at least MIN_BUSY cycles so a short write never frees early
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      busy_cnt_q <= hmap_pkg::CNT_ZERO;
    else if (i_clk_en)
    begin
      if (state_q == ST_IDLE && wr_start)
        busy_cnt_q <= MIN_BUSY[hmap_pkg::BUSY_CNT_W-1:0];
      else if (busy_cnt_q != hmap_pkg::CNT_ZERO)
        busy_cnt_q <= busy_cnt_q - hmap_pkg::CNT_ONE;
    end
  end

  // Short write: strobe ends while busy; long write: ends after free, data at end anyway
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_q <= ST_IDLE;
      data_taken_q <= 1'b0;
      wdata_q <= hmap_pkg::DATA_RESET;
    end
    else if (i_clk_en)
    begin
      case (state_q)
        ST_IDLE:
        begin
          data_taken_q <= 1'b0;
          if (wr_start)
            state_q <= ST_BUSY;
        end
        ST_BUSY:
        begin
          if (wr_end && !data_taken_q)
          begin
            wdata_q <= bus_s3_q;
            data_taken_q <= 1'b1;
          end
          if (busy_done && (data_taken_q || wr_end))
            state_q <= ST_COMMIT;
          else if (busy_done)
            state_q <= ST_WAIT_END;
        end
        ST_WAIT_END:
        begin
          if (wr_end)
          begin
            wdata_q <= bus_s3_q;
            state_q <= ST_COMMIT;
          end
        end
        ST_COMMIT:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Address latch at the end of the address phase, advance after each commit
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      addr_q <= hmap_pkg::ADDR_RESET;
    else if (i_clk_en)
    begin
      if (alat_act_q && !alat_act)
        addr_q <= bus_s3_q;
      else if (state_q == ST_COMMIT)
        addr_q <= addr_q + hmap_pkg::ADDR_STEP;
    end
  end

  // Memory write strobe registered from the commit state
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_mem_we <= 1'b0;
      o_mem_addr <= hmap_pkg::ADDR_RESET;
      o_mem_data <= hmap_pkg::DATA_RESET;
    end
    else if (i_clk_en)
    begin
      o_mem_we <= (state_q == ST_COMMIT);
      o_mem_addr <= addr_q;
      o_mem_data <= wdata_q;
    end
  end

  // ---------------------------------------------------------------
  // Pins back to the host
  // ---------------------------------------------------------------
  // Busy while the least time runs and while a short write commits. A long write has
  // already freed the port in wait-for-end, so its commit keeps the acknowledge low
  // rather than pulsing busy again after the host has been told it may go on.
  assign port.port_acknowledge_n = (state_q == ST_BUSY) ||
                                   ((state_q == ST_COMMIT) && data_taken_q);
  // Reads lie outside this block, so the device never turns the bus around
  assign port.bus_from_device = hmap_pkg::DATA_RESET;
  assign port.bus_from_device_oe = 1'b0;
endmodule : hmap_device

// ### hmap_host.sv
/*
  Host end of the host memory access port: runs an address phase or a write on request,
  honouring the acknowledge.
  Assumes the device end shares i_clk; acknowledge is still synchronised.
*/
module hmap_host (
  input wire logic i_clk, // System clock
  input wire logic i_reset, // Synchronous reset, active high
  input wire logic i_clk_en, // Clock enable
  hmap_if.host port, // Pin side
  input wire logic i_req, // Request pulse or level
  input wire logic i_req_is_addr, // 1 address phase, 0 write
  input wire logic [15:0] i_req_data, // Address or data word
  output logic o_ready // Idle and port free
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_DRIVE = 2'b01,
    H_HOLD = 2'b11,
    H_GAP = 2'b10
  } hstate_t;

  hstate_t st_q;
  logic ack_s1_q, ack_s2_q, is_addr_q, seen_busy_q;
  logic [15:0] data_q;

  // Acknowledge synchroniser
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ack_s1_q <= 1'b1;
      ack_s2_q <= 1'b1;
    end
    else if (i_clk_en)
    begin
      ack_s1_q <= port.port_acknowledge_n;
      ack_s2_q <= ack_s1_q;
    end
  end

  assign o_ready = (st_q == H_IDLE) && !ack_s2_q;

  // Remembers that the device answered the current write; the synchronised acknowledge
  // lags the pins by two cycles, so without this the host would call the port free early
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      seen_busy_q <= 1'b0;
    else if (i_clk_en)
    begin
      if (st_q == H_IDLE)
        seen_busy_q <= 1'b0;
      else if (ack_s2_q)
        seen_busy_q <= 1'b1;
    end
  end

  // Sequence: drive strobe, hold, release, then one gap so phases never merge
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      st_q <= H_IDLE;
      is_addr_q <= 1'b0;
      data_q <= hmap_pkg::DATA_RESET;
    end
    else if (i_clk_en)
    begin
      case (st_q)
        H_IDLE:
          if (i_req && o_ready)
          begin
            is_addr_q <= i_req_is_addr;
            data_q <= i_req_data;
            st_q <= H_DRIVE;
          end
        H_DRIVE:
          st_q <= H_HOLD;
        H_HOLD:
          // A write stays strobed while the request is held, giving a long write
          if (is_addr_q || !i_req)
            st_q <= H_GAP;
        H_GAP:
          // A write must have shown busy first; a device that never answers stalls here
          if (is_addr_q || seen_busy_q || ack_s2_q)
            st_q <= H_IDLE;
        default:
          st_q <= H_IDLE;
      endcase
    end
  end

  // Strobes active for DRIVE and HOLD; data stays on the bus through GAP for hold time
  assign port.port_select_n = !((st_q == H_DRIVE) || (st_q == H_HOLD));
  assign port.address_latch_strobe = is_addr_q && ((st_q == H_DRIVE) || (st_q == H_HOLD));
  assign port.write_strobe_n = !(!is_addr_q && ((st_q == H_DRIVE) || (st_q == H_HOLD)));
  assign port.read_strobe_n = 1'b1;
  assign port.bus_from_host = data_q;
  assign port.bus_from_host_oe = (st_q != H_IDLE);
endmodule : hmap_host

// ### hmap_asserts.sv
/*
  Checker on the pins between the host end and the device end.
  Assumes one clock and a synchronous active-high reset.
*/
module hmap_asserts (
  input wire logic i_clk, // Clock
  input wire logic i_reset, // Reset
  input wire logic port_select_n, // Select
  input wire logic address_latch_strobe, // Latch strobe
  input wire logic write_strobe_n, // Write strobe
  input wire logic read_strobe_n, // Read strobe
  input wire logic port_acknowledge_n, // High while busy
  input wire logic bus_from_host_oe, // Host drives bus
  input wire logic [15:0] shared_addr_data_bus // Bus level
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // Decodes
  // --------
  logic addr_on;
  logic wr_on;
  // Phases as seen on the pins
  assign addr_on = !port_select_n && address_latch_strobe;
  assign wr_on = !port_select_n && !write_strobe_n;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence wr_start_s;
    wr_on && !$past(wr_on);
  endsequence
  sequence wr_end_s;
    $past(wr_on) && !wr_on;
  endsequence
  // Busy flag must be clear whenever a phase opens
  ack_free_addr_a: assert property (addr_on && !$past(addr_on) |-> !port_acknowledge_n)
    else $error("address phase opened while busy");
  ack_free_write_a: assert property (wr_start_s |-> !port_acknowledge_n)
    else $error("write opened while busy");
  busy_raise_a: assert property (wr_start_s |-> ##[1:4] port_acknowledge_n)
    else $error("busy not raised after write start");
  // Busy spans the least time, then ends in bounded time
  busy_hold_a: assert property ($rose(port_acknowledge_n) |-> port_acknowledge_n[*2])
    else $error("busy dropped too soon");
  busy_end_a: assert property ($rose(port_acknowledge_n) |-> ##[2:12] !port_acknowledge_n)
    else $error("busy never cleared");
  phase_apart_a: assert property (addr_on |-> write_strobe_n && read_strobe_n)
    else $error("strobe during address phase");
  addr_hold_a: assert property (addr_on |-> bus_from_host_oe)
    else $error("address not driven");
  // Data must not move inside a write and must outlast its end
  data_hold_a: assert property (wr_on && $past(wr_on) |-> $stable(shared_addr_data_bus))
    else $error("write data moved");
  data_end_a: assert property (wr_end_s |-> bus_from_host_oe)
    else $error("write data gone at write end");
endmodule : hmap_asserts

// ### testbench.sv
/*
  Bench joining both port ends, writing words and comparing what reaches memory.
  Assumes the package, carrier, both ends and the checker are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_clk_en = 1'b1;
  logic i_req = 1'b0;
  logic i_req_is_addr = 1'b0;
  logic [15:0] i_req_data = 16'h0000;
  logic o_ready;
  logic o_mem_we;
  logic [15:0] o_mem_addr;
  logic [15:0] o_mem_data;
  logic [15:0] got_a[$];
  logic [15:0] got_d[$];
  logic [15:0] exp_a[$];
  logic [15:0] exp_d[$];
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int waited = 0;
  hmap_if port ();
  hmap_host hmap_host_inst (.i_clk(i_clk), .i_reset(i_reset), .i_clk_en(i_clk_en), .port(port),
    .i_req(i_req), .i_req_is_addr(i_req_is_addr), .i_req_data(i_req_data), .o_ready(o_ready));
  hmap_device hmap_device_inst (.i_clk(i_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
    .port(port), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data));
  hmap_asserts hmap_asserts_inst (.i_clk(i_clk), .i_reset(i_reset),
    .port_select_n(port.port_select_n), .address_latch_strobe(port.address_latch_strobe),
    .write_strobe_n(port.write_strobe_n), .read_strobe_n(port.read_strobe_n),
    .port_acknowledge_n(port.port_acknowledge_n), .bus_from_host_oe(port.bus_from_host_oe),
    .shared_addr_data_bus(port.shared_addr_data_bus));
  // --------
  // Clock, timeout, capture
  // --------
  always #10 i_clk = ~i_clk;
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  // Memory pulse lasts one cycle, so look once per cycle off the edge
  always @(negedge i_clk)
  begin
    if (o_mem_we === 1'b1)
    begin
      got_a.push_back(o_mem_addr);
      got_d.push_back(o_mem_data);
    end
  end
  // --------
  // Tasks
  // --------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One host request, held until the edge that takes it; with hold set it stays up through
  // busy and back to free, so the write ends after the acknowledge (a long write)
  task automatic send(input logic is_addr, input logic [15:0] value, input bit hold = 1'b0);
    int n;
    n = 0;
    while (o_ready !== 1'b1 && n < 50)
    begin
      @(negedge i_clk);
      n++;
    end
    if (o_ready !== 1'b1)
      check("host ready", {15'h0000, o_ready}, 16'h0001);
    i_req = 1'b1;
    i_req_is_addr = is_addr;
    i_req_data = value;
    @(negedge i_clk);
    while (hold && port.port_acknowledge_n !== 1'b1 && n < 80)
    begin
      @(negedge i_clk);
      n++;
    end
    while (hold && port.port_acknowledge_n !== 1'b0 && n < 110)
    begin
      @(negedge i_clk);
      n++;
    end
    if (hold)
    begin
      check("long ack", {15'h0000, port.port_acknowledge_n}, 16'h0000);
      check("long strobe", {15'h0000, port.write_strobe_n}, 16'h0000);
    end
    i_req = 1'b0;
  endtask : send
  task automatic burst(input logic [15:0] base, input int count, input logic [15:0] seed);
    send(1'b1, base);
    for (int i = 0; i < count; i++)
    begin
      send(1'b0, seed ^ 16'(i));
      exp_a.push_back(base + 16'(i));
      exp_d.push_back(seed ^ 16'(i));
    end
  endtask : burst
  // Waits for all words and a free port, then compares in order
  task automatic settle(input string name);
    int n;
    n = 0;
    while ((got_a.size() < exp_a.size() || port.port_acknowledge_n !== 1'b0) && n < 80)
    begin
      @(negedge i_clk);
      n++;
    end
    check("write count", 16'(got_a.size()), 16'(exp_a.size()));
    while (exp_a.size() > 0 && got_a.size() > 0)
    begin
      check("mem addr", got_a.pop_front(), exp_a.pop_front());
      check("mem data", got_d.pop_front(), exp_d.pop_front());
    end
    check("ack free", {15'h0000, port.port_acknowledge_n}, 16'h0000);
    $display("Test %s done", name);
  endtask : settle
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // Address phases, back-to-back writes, wrap, resume, reset
  initial
  begin
    repeat (6) @(negedge i_clk);
    i_reset = 1'b0;
    burst(16'h1230, 3, 16'hA5A5);
    settle("burst");
    burst(16'hFFFF, 2, 16'h5A5A);
    settle("wrap");
    send(1'b0, 16'hFFFF);
    exp_a.push_back(16'h0001);
    exp_d.push_back(16'hFFFF);
    settle("resume");
    send(1'b1, 16'h0100);
    burst(16'h0200, 1, 16'h0000);
    settle("second address");
    // Long write: strobe held past the busy time, then a short write right behind it
    send(1'b1, 16'h4000);
    send(1'b0, 16'h1111, 1'b1);
    send(1'b0, 16'h2222);
    exp_a.push_back(16'h4000);
    exp_d.push_back(16'h1111);
    exp_a.push_back(16'h4001);
    exp_d.push_back(16'h2222);
    settle("long write");
    // Clock enable low in mid-write freezes both ends; the write must still land
    send(1'b0, 16'h7E7E);
    exp_a.push_back(16'h4002);
    exp_d.push_back(16'h7E7E);
    while (port.port_acknowledge_n !== 1'b1 && waited < 20)
    begin
      @(negedge i_clk);
      waited++;
    end
    i_clk_en = 1'b0;
    repeat (3) @(negedge i_clk);
    check("frozen busy", {15'h0000, port.port_acknowledge_n}, 16'h0001);
    i_clk_en = 1'b1;
    settle("clock enable");
    i_reset = 1'b1;
    repeat (2) @(negedge i_clk);
    i_reset = 1'b0;
    send(1'b0, 16'h3C3C);
    exp_a.push_back(hmap_pkg::ADDR_RESET);
    exp_d.push_back(16'h3C3C);
    settle("after reset");
    tally_and_finish();
  end
endmodule : testbench
